//--- core/psd_slot.sv
// Common task, event, interrupt-enable and enable logic of one slot
`timescale 1ns/1ps
module psd_slot (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [9:0] regIdx,
	input wire logic [31:0] wdata,
	input wire logic [psd_pkg::PSD_NEV-1:0] evIn,
	input wire logic [psd_pkg::PSD_NTASK-1:0] hwTask,
	output logic [psd_pkg::PSD_NTASK-1:0] taskQ,
	output logic [psd_pkg::PSD_NEV-1:0] eventQ,
	output logic [psd_pkg::PSD_NEV-1:0] intenQ,
	output logic enableQ,
	output logic irqQ,
	output logic [31:0] rdata
);
	import psd_pkg::*;

	// ----------------------------------------------------------------
	// Enable and interrupt enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enableQ <= PSD_ENABLE_RESET;
		end else if (wrEn && regIdx == PSD_IDX_ENABLE) begin
			enableQ <= wdata[0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			intenQ <= PSD_INTEN_RESET;
		end else if (wrEn && regIdx == PSD_IDX_INTEN) begin
			intenQ <= wdata[PSD_NEV-1:0];
		end else if (wrEn && regIdx == PSD_IDX_INTENSET) begin
			intenQ <= intenQ | wdata[PSD_NEV-1:0];
		end else if (wrEn && regIdx == PSD_IDX_INTENCLR) begin
			intenQ <= intenQ & ~wdata[PSD_NEV-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Tasks and events
	// ----------------------------------------------------------------
	// A disabled slot ignores tasks and events alike.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			taskQ <= '0;
		end else begin
			for (int k = 0; k < PSD_NTASK; k++) begin
				taskQ[k] <= enableQ && (hwTask[k] || (wrEn && wdata[0]
					&& regIdx == PSD_IDX_TASK + 10'(k)));
			end
		end
	end

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eventQ <= PSD_EVENT_RESET;
		end else begin
			for (int k = 0; k < PSD_NEV; k++) begin
				eventQ[k] <= (eventQ[k] && !(wrEn && !wdata[0]
					&& regIdx == PSD_IDX_EVENT + 10'(k)))
					|| (enableQ && evIn[k]);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqQ <= 1'b0;
		end else begin
			irqQ <= |(eventQ & intenQ);
		end
	end

	// ----------------------------------------------------------------
	// Read view; set and clear companions read back the main register
	// ----------------------------------------------------------------
	always_comb begin
		rdata = '0;
		if (regIdx == PSD_IDX_INTEN || regIdx == PSD_IDX_INTENSET
			|| regIdx == PSD_IDX_INTENCLR) begin
			rdata[PSD_NEV-1:0] = intenQ;
		end else if (regIdx == PSD_IDX_ENABLE) begin
			rdata[0] = enableQ;
		end else if (regIdx >= PSD_IDX_EVENT
			&& regIdx < PSD_IDX_EVENT + 10'(PSD_NEV)) begin
			rdata[0] = eventQ[2'(regIdx - PSD_IDX_EVENT)];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	taskWrite_a: assert property (@(posedge clk) disable iff (!rst_b)
		enableQ && wrEn && regIdx == PSD_IDX_TASK && wdata[0]
		|=> taskQ[0])
		else $error("task write did not trigger task");

	taskHold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!enableQ |=> taskQ == '0)
		else $error("task fired while slot disabled");

	eventHold_a: assert property (@(posedge clk) disable iff (!rst_b)
		eventQ[0] && !(wrEn && regIdx == PSD_IDX_EVENT && !wdata[0])
		|=> eventQ[0])
		else $error("event cleared without a zero write");

	eventClear_a: assert property (@(posedge clk) disable iff (!rst_b)
		wrEn && regIdx == PSD_IDX_EVENT && !wdata[0]
		&& !(enableQ && evIn[0]) |=> !eventQ[0])
		else $error("zero write did not clear event");

	intenSet_a: assert property (@(posedge clk) disable iff (!rst_b)
		wrEn && regIdx == PSD_IDX_INTENSET
		|=> intenQ == ($past(intenQ) | $past(wdata[PSD_NEV-1:0])))
		else $error("set companion misbehaved");

	intenClr_a: assert property (@(posedge clk) disable iff (!rst_b)
		wrEn && regIdx == PSD_IDX_INTENCLR
		|=> intenQ == ($past(intenQ) & ~$past(wdata[PSD_NEV-1:0])))
		else $error("clear companion misbehaved");

	irqGate_a: assert property (@(posedge clk) disable iff (!rst_b)
		(eventQ & intenQ) == '0 |=> !irqQ)
		else $error("interrupt raised without enabled event");

endmodule : psd_slot

//--- core/psd_pkg.sv
// Package: constants, carrier types and decode functions of the slot decoder
package psd_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [31:0] PSD_REGION_BASE = 32'h4000_0000;
	localparam logic [14:0] PSD_REGION_TAG = 15'h2000;
	localparam int PSD_SLOTS = 32;
	localparam int PSD_SLOT_BYTES = 4096;
	localparam int PSD_SLOT_REGS = 1024;
	localparam int PSD_ID_LSB = 12;
	localparam int PSD_ID_MSB = 16;
	localparam int PSD_IDX_LSB = 2;
	localparam int PSD_IDX_MSB = 11;

	// ----------------------------------------------------------------
	// Common registers inside each slot (register index)
	// ----------------------------------------------------------------
	localparam int PSD_NEV = 4;
	localparam int PSD_NTASK = 4;
	localparam logic [9:0] PSD_IDX_TASK = 10'h000;
	localparam logic [9:0] PSD_IDX_EVENT = 10'h040;
	localparam logic [9:0] PSD_IDX_INTEN = 10'h0C0;
	localparam logic [9:0] PSD_IDX_INTENSET = 10'h0C1;
	localparam logic [9:0] PSD_IDX_INTENCLR = 10'h0C2;
	localparam logic [9:0] PSD_IDX_ENABLE = 10'h140;
	localparam logic [PSD_NEV-1:0] PSD_INTEN_RESET = 4'h0;
	localparam logic [PSD_NEV-1:0] PSD_EVENT_RESET = 4'h0;
	localparam logic PSD_ENABLE_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} psd_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] rdata;
	} psd_rsp_t;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic psd_in_region(input logic [31:0] addr);
		return addr[31:17] == PSD_REGION_TAG;
	endfunction : psd_in_region

	function automatic logic [4:0] psd_slot_id(input logic [31:0] addr);
		return addr[PSD_ID_MSB:PSD_ID_LSB];
	endfunction : psd_slot_id

	function automatic logic [9:0] psd_reg_idx(input logic [31:0] addr);
		return addr[PSD_IDX_MSB:PSD_IDX_LSB];
	endfunction : psd_reg_idx

endpackage : psd_pkg

//--- core/psd_decoder.sv
// Peripheral slot decoder: maps CPU accesses onto 32 fixed 4 KiB slots
// Contract
// - CPU controls peripherals only through configuration and task writes.
// - Events set an event register; interrupt only when enabled for it.
// - Each slot spans 0x1000 bytes, 1024 registers of 32 bits.
// - Slot identifier follows directly from the base address.
// - 0x40000000 is slot 0, stepping one slot to 0x4001F000 as 31.
// - Peripherals on one identifier share that slot's common registers.
// - A task fires on a written 1 or a hardware task pulse.
// - An event stays set until software writes 0 to it.
// - Each slot drives one interrupt line indexed by its identifier.
// - Set and clear companions change only bits written as 1.
`timescale 1ns/1ps
module psd_decoder (
	input wire logic clk,
	input wire logic rst_b,
	input wire psd_pkg::psd_req_t cpuReq,
	output psd_pkg::psd_rsp_t cpuRspQ,
	output logic [psd_pkg::PSD_SLOTS-1:0] slotSelQ,
	output logic [9:0] regIdxQ,
	input wire logic [psd_pkg::PSD_SLOTS-1:0][psd_pkg::PSD_NEV-1:0] evIn,
	input wire logic [psd_pkg::PSD_SLOTS-1:0][psd_pkg::PSD_NTASK-1:0] hwTask,
	output logic [psd_pkg::PSD_SLOTS-1:0][psd_pkg::PSD_NTASK-1:0] taskQ,
	output logic [psd_pkg::PSD_SLOTS-1:0][psd_pkg::PSD_NEV-1:0] eventQ,
	output logic [psd_pkg::PSD_SLOTS-1:0] enableQ,
	output logic [psd_pkg::PSD_SLOTS-1:0] irqQ
);
	import psd_pkg::*;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic hit;
	logic [4:0] slotId;
	logic [9:0] regIdx;
	logic [PSD_SLOTS-1:0][31:0] slotRdata;
	logic [PSD_SLOTS-1:0][PSD_NEV-1:0] intenQ;

	assign hit = cpuReq.valid && psd_in_region(cpuReq.addr);
	assign slotId = psd_slot_id(cpuReq.addr);
	assign regIdx = psd_reg_idx(cpuReq.addr);

	// ----------------------------------------------------------------
	// Slots; peripherals sharing an identifier share one instance
	// ----------------------------------------------------------------
	for (genvar i = 0; i < PSD_SLOTS; i++) begin : gSlot
		psd_slot uSlot (
			.clk(clk),
			.rst_b(rst_b),
			.wrEn(hit && cpuReq.write && slotId == 5'(i)),
			.regIdx(regIdx),
			.wdata(cpuReq.wdata),
			.evIn(evIn[i]),
			.hwTask(hwTask[i]),
			.taskQ(taskQ[i]),
			.eventQ(eventQ[i]),
			.intenQ(intenQ[i]),
			.enableQ(enableQ[i]),
			.irqQ(irqQ[i]),
			.rdata(slotRdata[i])
		);
	end

	// ----------------------------------------------------------------
	// Response, one cycle after the request
	// ----------------------------------------------------------------
	// Accesses outside the region answer with err and read as zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cpuRspQ <= '0;
		end else begin
			cpuRspQ.valid <= cpuReq.valid;
			cpuRspQ.err <= cpuReq.valid && !psd_in_region(cpuReq.addr);
			cpuRspQ.rdata <= (hit && !cpuReq.write) ? slotRdata[slotId]
				: 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slotSelQ <= '0;
			regIdxQ <= '0;
		end else begin
			slotSelQ <= hit ? (PSD_SLOTS'(1) << slotId) : '0;
			regIdxQ <= hit ? regIdx : '0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	baseMap_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpuReq.valid && cpuReq.addr == 32'h4001_F000
		|=> slotSelQ == 32'h8000_0000 && regIdxQ == 10'h000)
		else $error("top slot base did not select slot 31");

	slotOne_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpuReq.valid && cpuReq.addr == 32'h4000_1000
		|=> slotSelQ == 32'h0000_0002)
		else $error("second slot base did not select slot 1");

	slotSpan_a: assert property (@(posedge clk) disable iff (!rst_b)
		hit |=> regIdxQ == $past(cpuReq.addr[11:2])
		&& $onehot(slotSelQ))
		else $error("register index or slot select wrong");

	outRange_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpuReq.valid && !hit |=> cpuRspQ.err && slotSelQ == '0)
		else $error("unmapped access not refused");

	irqLine_a: assert property (@(posedge clk) disable iff (!rst_b)
		(eventQ[5] & intenQ[5]) != '0 |=> irqQ[5])
		else $error("slot 5 interrupt not on line 5");

	slotZero_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpuReq.valid && cpuReq.addr == PSD_REGION_BASE
		|=> slotSelQ == 32'h0000_0001)
		else $error("region base did not select slot 0");

	rspPulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		!cpuReq.valid |=> !cpuRspQ.valid && slotSelQ == '0)
		else $error("response without a request");

	wrData_a: assert property (@(posedge clk) disable iff (!rst_b)
		cpuReq.valid && cpuReq.write |=> cpuRspQ.rdata == '0)
		else $error("write answered with data");

endmodule : psd_decoder

//--- sim/psd_cpu_model.sv
// CPU-side bus master model that issues requests to the slot decoder
`timescale 1ns/1ps
module psd_cpu_model (
	input wire logic clk,
	output psd_pkg::psd_req_t cpuReq
);
	import psd_pkg::*;
	initial cpuReq = '0;
	// --------------------------------------------------------------
	// Accesses
	// --------------------------------------------------------------
	// Peripherals are steered only by register writes; reads change nothing
	task automatic acc(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		cpuReq <= '{1'b1, w, a, d};
	endtask : acc
	// Ends the access by clearing valid at the next rising clock edge
	task automatic idle();
		@(posedge clk);
		cpuReq.valid <= 1'b0;
	endtask : idle
endmodule : psd_cpu_model

//--- sim/tb_top.sv
// Self-checking bench of the peripheral slot decoder
`timescale 1ns/1ps
module tb_top;
	import psd_pkg::*;
	typedef struct packed {
		logic err;
		logic [31:0] rd;
		logic [31:0] sel;
		logic [9:0] idx;
	} psd_exp_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	psd_req_t cpuReq;
	psd_rsp_t cpuRspQ;
	logic [31:0] slotSelQ, enableQ, irqQ, en;
	logic [9:0] regIdxQ;
	logic [31:0][3:0] evIn = '0, hwTask = '0, taskQ, eventQ;
	logic [31:0] rng = 32'h0000_643A;
	logic [31:0] d;
	psd_exp_t expQ[$];
	int n_fail = 0, compares = 0, cyc = 0;
	always #10 clk = ~clk;
	psd_cpu_model u_psd_cpu_model (.clk(clk), .cpuReq(cpuReq));
	psd_decoder u_psd_decoder (.clk(clk), .rst_b(rst_b), .cpuReq(cpuReq),
		.cpuRspQ(cpuRspQ), .slotSelQ(slotSelQ), .regIdxQ(regIdxQ),
		.evIn(evIn), .hwTask(hwTask), .taskQ(taskQ), .eventQ(eventQ),
		.enableQ(enableQ), .irqQ(irqQ));
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	function automatic logic [31:0] ad(input logic [4:0] s, logic [9:0] i);
		return {15'h2000, s, i, 2'b00};
	endfunction : ad
	task automatic chk_rsp(input psd_exp_t got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t rsp %h exp %h", $time, got, exp);
		end
	endtask : chk_rsp
	task automatic chk_port(input logic [191:0] got, exp, input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s %h exp %h", $time, m, got, exp);
		end
	endtask : chk_port
	// Expected answer is noted before the request goes out
	task automatic bus(input logic w, input logic [31:0] a, d, rd);
		logic inR;
		inR = a[31:17] == 15'h2000;
		expQ.push_back({!inR, rd, inR ? 32'h0000_0001 << a[16:12] : 32'h0,
			inR ? a[11:2] : 10'h000});
		u_psd_cpu_model.acc(w, a, d);
	endtask : bus
	always @(negedge clk) begin
		if (cpuRspQ.valid === 1'b1) begin
			chk_rsp({cpuRspQ.err, cpuRspQ.rdata, slotSelQ, regIdxQ},
				expQ.size() ? expQ.pop_front() : '1);
		end
	end
	task automatic give_verdict();
		$display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Scenario length is well under this ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk_port({eventQ, irqQ, enableQ}, '0, "reset");
		for (int i = 0; i < 32; i++) begin
			d = xs();
			en[i] = d[0];
			bus(1'b1, ad(i, 10'h140), d, 32'h0);
		end
		for (int i = 0; i < 32; i++) bus(1'b0, ad(i, 10'h140), 0, en[i]);
		bus(1'b0, 32'h4000_0000, 0, 32'h0);
		bus(1'b0, 32'h4000_1000, 0, 32'h0);
		bus(1'b0, 32'h4001_F000, 0, 32'h0);
		bus(1'b0, ad(xs(), 10'h3FF), 0, 32'h0);
		bus(1'b0, 32'h4002_0000, 0, 32'h0);
		bus(1'b1, 32'h3FFF_FFFC, 32'h1, 32'h0);
		u_psd_cpu_model.idle();
		repeat (2) @(negedge clk);
		chk_port(enableQ, en, "enable");
		$display("Test decode done");
		bus(1'b1, ad(3, 10'h140), 32'h1, 32'h0);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, ad(3, k), 32'h1, 32'h0);
			u_psd_cpu_model.idle();
			@(negedge clk);
			chk_port(taskQ, 128'h1 << (12 + k), "task");
			@(posedge clk) hwTask[3] <= 4'h1 << k;
			@(posedge clk) hwTask <= '0;
			@(negedge clk);
			chk_port(taskQ, 128'h1 << (12 + k), "hwtask");
		end
		bus(1'b1, ad(3, 10'h140), 32'h0, 32'h0);
		bus(1'b1, ad(3, 10'h001), 32'h1, 32'h0);
		hwTask[3] <= 4'hF;
		u_psd_cpu_model.idle();
		hwTask <= '0;
		@(negedge clk);
		chk_port(taskQ, '0, "off task");
		$display("Test tasks done");
		bus(1'b1, ad(5, 10'h140), 32'h1, 32'h0);
		bus(1'b1, ad(5, 10'h0C1), 32'h4, 32'h0);
		bus(1'b1, ad(5, 10'h0C2), 32'h0, 32'h0);
		bus(1'b0, ad(5, 10'h0C2), 0, 32'h4);
		u_psd_cpu_model.idle();
		@(posedge clk) evIn[5] <= 4'h1;
		@(posedge clk) evIn <= '0;
		repeat (2) @(negedge clk);
		chk_port({eventQ, irqQ}, 160'h1 << 52, "masked");
		@(posedge clk) evIn[5] <= 4'h4;
		@(posedge clk) evIn <= '0;
		repeat (2) @(negedge clk);
		chk_port(irqQ, 32'h0000_0020, "irq");
		bus(1'b1, ad(5, 10'h042), 32'h1, 32'h0);
		bus(1'b0, ad(5, 10'h042), 0, 32'h1);
		bus(1'b1, ad(5, 10'h042), 32'h0, 32'h0);
		bus(1'b1, ad(5, 10'h040), 32'h0, 32'h0);
		bus(1'b1, ad(5, 10'h0C2), 32'h4, 32'h0);
		bus(1'b0, ad(5, 10'h0C0), 0, 32'h0);
		bus(1'b1, ad(5, 10'h0C0), 32'h0000_000B, 32'h0);
		bus(1'b0, ad(5, 10'h0C1), 0, 32'h0000_000B);
		u_psd_cpu_model.idle();
		repeat (2) @(negedge clk);
		chk_port({eventQ, irqQ}, '0, "cleared");
		$display("Test events done");
		give_verdict();
	end
endmodule : tb_top
